// ==== verilog/scpu_core.sv ====
// execution logic for one opcode group of the speech cpu, with apb access
`include "scpu_map.svh"
module scpu_core #(
   parameter logic [`SCPU_PC_W-1:0] IRQ_VECTOR = `SCPU_RST_IRQ_VEC
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic timer_irq,
   output logic [`SCPU_SPTR_W-1:0] rom_addr,
   input wire logic [7:0] rom_data,
   input wire logic host_enable_two_n,
   output logic ready_n,
   output logic prescaler_internal_source,
   output logic power_down
);
   timeunit 1ns;
   timeprecision 1ps;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [7:0] bit_mask(input logic [2:0] pos);
      bit_mask = 8'h01 << pos;
   endfunction : bit_mask

   // push shifts everything down; the deepest entry falls off the end
   function automatic scpu_pkg::scpu_stack_t stk_push(
      input scpu_pkg::scpu_stack_t s,
      input logic [`SCPU_PC_W-1:0] v);
      scpu_pkg::scpu_stack_t r;
      r = s;
      for (int i = `SCPU_STK_N - 1; i > 0; i--) begin
         r[i] = s[i-1];
      end
      r[0] = v;
      stk_push = r;
   endfunction : stk_push

   function automatic scpu_pkg::scpu_stack_t stk_pop(
      input scpu_pkg::scpu_stack_t s);
      scpu_pkg::scpu_stack_t r;
      r = s;
      for (int i = 0; i < `SCPU_STK_N - 1; i++) begin
         r[i] = s[i+1];
      end
      r[`SCPU_STK_N-1] = '0;
      stk_pop = r;
   endfunction : stk_pop

   function automatic logic [`SCPU_STK_CNT_W-1:0] depth_up(
      input logic [`SCPU_STK_CNT_W-1:0] dp);
      if (dp == `SCPU_STK_CNT_W'(`SCPU_STK_N)) begin
         depth_up = dp;
      end else begin
         depth_up = dp + `SCPU_STK_CNT_W'(1);
      end
   endfunction : depth_up

   function automatic logic [`SCPU_STK_CNT_W-1:0] depth_dn(
      input logic [`SCPU_STK_CNT_W-1:0] dp);
      if (dp == '0) begin
         depth_dn = dp;
      end else begin
         depth_dn = dp - `SCPU_STK_CNT_W'(1);
      end
   endfunction : depth_dn

   // ************************************************************
   // state
   // ************************************************************
   scpu_pkg::scpu_regs_t q;
   scpu_pkg::scpu_regs_t d;

   logic access;
   logic take;
   logic wr;
   logic do_op;
   logic [7:0] op;
   logic [`SCPU_PC_W-1:0] pc_inc;
   logic [7:0] mem_x;
   logic [`SCPU_ACC_W-1:0] mem_ext;
   logic [8:0] diff8;

   always_comb begin
      d = q;
      access = 1'b0;
      take = 1'b0;
      wr = 1'b0;
      do_op = 1'b0;
      op = 8'h00;
      pc_inc = '0;
      mem_x = 8'h00;
      mem_ext = '0;
      diff8 = 9'h000;

      d.en_s1 = host_enable_two_n;
      d.en_s2 = q.en_s1;
      d.pready = 1'b0;
      d.pslverr = 1'b0;

      // a command is not answered while a rom lookup is in flight
      access = psel && penable && !q.pready;
      take = access && (q.st == scpu_pkg::SCPU_ST_IDLE);
      wr = take && pwrite;
      d.pready = take;

      // ************************************************************
      // register reads
      // ************************************************************
      if (take && !pwrite) begin
         unique case (paddr)
            `SCPU_REG_CMD: d.prdata = {24'h00_0000, q.last_op};
            `SCPU_REG_ACC: d.prdata = 32'(q.acc);
            `SCPU_REG_XPTR: d.prdata = 32'(q.xptr);
            `SCPU_REG_STATUS: begin
               d.prdata = 32'h0000_0000;
               d.prdata[`SCPU_ST_FLAG] = q.flag;
               d.prdata[`SCPU_ST_SEXT] = q.sext;
               d.prdata[`SCPU_ST_DOWN] = q.down;
               d.prdata[`SCPU_ST_RDY_N] = q.rdy_n;
               d.prdata[`SCPU_ST_PRESC] = q.presc_int;
               d.prdata[`SCPU_ST_DEPTH_LSB +: `SCPU_STK_CNT_W] = q.depth;
            end
            `SCPU_REG_PC: d.prdata = 32'(q.pc);
            `SCPU_REG_SPTR: d.prdata = 32'(q.sptr);
            `SCPU_REG_SER: begin
               d.prdata = 32'(q.ser);
               d.prdata[`SCPU_SER_CNT_LSB +: `SCPU_SER_CNT_W] = q.ser_cnt;
            end
            `SCPU_REG_STK_TOP: d.prdata = 32'(q.stk[0]);
            `SCPU_REG_RAM_IDX: d.prdata = 32'(q.ram_idx);
            `SCPU_REG_RAM_DATA: d.prdata = 32'(q.ram[q.ram_idx]);
            default: begin
               d.prdata = 32'h0000_0000;
               d.pslverr = 1'b1;
            end
         endcase
      end

      // ************************************************************
      // register writes
      // ************************************************************
      if (wr) begin
         unique case (paddr)
            `SCPU_REG_CMD: begin
               do_op = !q.down;
               op = pwdata[7:0];
               d.last_op = pwdata[7:0];
            end
            `SCPU_REG_ACC: d.acc = pwdata[`SCPU_ACC_W-1:0];
            `SCPU_REG_XPTR: d.xptr = pwdata[`SCPU_X_W-1:0];
            `SCPU_REG_STATUS: begin
               d.flag = pwdata[`SCPU_ST_FLAG];
               d.sext = pwdata[`SCPU_ST_SEXT];
               // software wakes the core by writing 0; a written 1 leaves down as it is
               if (!pwdata[`SCPU_ST_DOWN]) begin
                  d.down = 1'b0;
               end
            end
            `SCPU_REG_PC: d.pc = pwdata[`SCPU_PC_W-1:0];
            `SCPU_REG_SPTR: d.sptr = pwdata[`SCPU_SPTR_W-1:0];
            `SCPU_REG_RAM_IDX: d.ram_idx = pwdata[`SCPU_RAM_AW-1:0];
            `SCPU_REG_RAM_DATA: d.ram[q.ram_idx] = pwdata[7:0];
            `SCPU_REG_SER, `SCPU_REG_STK_TOP: ;
            default: d.pslverr = 1'b1;
         endcase
      end

      // ************************************************************
      // opcode execution
      // ************************************************************
      pc_inc = q.pc + `SCPU_PC_W'(1);
      mem_x = q.ram[q.xptr[`SCPU_RAM_AW-1:0]];
      mem_ext = q.sext ? {{2{mem_x[7]}}, mem_x} : {2'b00, mem_x};
      diff8 = {1'b0, q.acc[7:0]} - {1'b0, mem_x};

      if (do_op) begin
         d.pc = pc_inc;
         if (op[7]) begin
            if (q.flag) begin
               d.pc = {pc_inc[`SCPU_PC_W-1:`SCPU_PAGE_LSB], op[6:0]};
            end
            d.flag = 1'b1;
         end else if (op[7:3] == `SCPU_OP_SET_BASE) begin
            d.ram[q.xptr[`SCPU_RAM_AW-1:0]] = mem_x | bit_mask(op[2:0]);
            d.flag = 1'b1;
         end else if (op[7:3] == `SCPU_OP_CLR_BASE) begin
            d.ram[q.xptr[`SCPU_RAM_AW-1:0]] = mem_x & ~bit_mask(op[2:0]);
            d.flag = 1'b1;
         end else begin
            unique case (op)
               `SCPU_OP_SER_LOOKUP: begin
                  // return address goes on the stack while rom is read
                  d.stk = stk_push(q.stk, pc_inc);
                  d.depth = depth_up(q.depth);
                  d.rom_addr = q.sptr;
                  d.st = scpu_pkg::SCPU_ST_LOOK;
               end
               `SCPU_OP_POP: begin
                  d.stk = stk_pop(q.stk);
                  d.depth = depth_dn(q.depth);
                  d.flag = 1'b1;
               end
               `SCPU_OP_RET_IRQ: begin
                  // only A, X and flag were banked; pc comes from the stack top
                  d.acc = q.acc_save;
                  d.xptr = q.xptr_save;
                  d.flag = q.flag_save;
                  d.pc = q.stk[0];
                  d.stk = stk_pop(q.stk);
                  d.depth = depth_dn(q.depth);
               end
               `SCPU_OP_RET_SUB: begin
                  d.pc = q.stk[0];
                  d.stk = stk_pop(q.stk);
                  d.depth = depth_dn(q.depth);
                  d.flag = 1'b1;
               end
               `SCPU_OP_PRESC_INT: begin
                  d.presc_int = 1'b1;
                  d.flag = 1'b1;
               end
               `SCPU_OP_RDY_LOW: begin
                  if (q.en_s2) begin
                     d.rdy_n = 1'b0;
                  end
                  d.flag = 1'b1;
               end
               `SCPU_OP_SHL: begin
                  d.acc = {q.acc[`SCPU_ACC_W-2:0], 1'b0};
                  d.flag = 1'b1;
               end
               `SCPU_OP_SHR: begin
                  d.acc = {q.acc[`SCPU_ACC_W-1], q.acc[`SCPU_ACC_W-1:1]};
                  d.flag = 1'b1;
               end
               `SCPU_OP_POWER_DOWN: begin
                  // ram, pointers and stack are kept; rom address and prescaler source drop
                  d.down = 1'b1;
                  d.rom_addr = '0;
                  d.presc_int = 1'b0;
               end
               `SCPU_OP_SUB_MEM: begin
                  d.acc = q.acc - mem_ext;
                  d.flag = !diff8[8];
               end
               default: ;
            endcase
         end
      end else if (timer_irq && !q.down && q.st == scpu_pkg::SCPU_ST_IDLE) begin
         // timer entry banks A, X and flag only
         d.acc_save = q.acc;
         d.xptr_save = q.xptr;
         d.flag_save = q.flag;
         d.stk = stk_push(q.stk, q.pc);
         d.depth = depth_up(q.depth);
         d.pc = IRQ_VECTOR;
      end

      // ************************************************************
      // second cycle of the serializer lookup
      // ************************************************************
      if (q.st == scpu_pkg::SCPU_ST_LOOK) begin
         d.ser = rom_data;
         d.ser_cnt = `SCPU_SER_FULL;
         d.sptr = q.sptr + `SCPU_SPTR_W'(1);
         d.stk = stk_pop(q.stk);
         d.depth = depth_dn(q.depth);
         d.flag = 1'b1;
         d.st = scpu_pkg::SCPU_ST_IDLE;
      end

      // host acknowledge wins over a same-cycle request to go low
      if (!q.en_s2) begin
         d.rdy_n = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q <= '0;
         q.st <= scpu_pkg::SCPU_ST_IDLE;
         q.pc <= `SCPU_RST_PC;
         q.rdy_n <= 1'b1;
         q.en_s1 <= 1'b1;
         q.en_s2 <= 1'b1;
      end else begin
         q <= d;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign prdata = q.prdata;
   assign pready = q.pready;
   assign pslverr = q.pslverr;
   assign rom_addr = q.rom_addr;
   assign ready_n = q.rdy_n;
   assign prescaler_internal_source = q.presc_int;
   assign power_down = q.down;

endmodule : scpu_core

// ==== shared/scpu_map.svh ====
// register offsets, field positions, widths, opcodes and reset values
`ifndef SCPU_MAP_SVH
`define SCPU_MAP_SVH

// ************************************************************
// widths
// ************************************************************
`define SCPU_ACC_W 10
`define SCPU_X_W 8
`define SCPU_PC_W 12
`define SCPU_SPTR_W 14
`define SCPU_STK_N 5
`define SCPU_STK_CNT_W 3
`define SCPU_RAM_AW 7
`define SCPU_RAM_N 128
`define SCPU_SER_CNT_W 4
`define SCPU_SER_FULL 4'h8
`define SCPU_PAGE_LSB 7

// ************************************************************
// opcodes
// ************************************************************
`define SCPU_OP_SER_LOOKUP 8'h59
`define SCPU_OP_POP 8'h57
`define SCPU_OP_CLR_BASE 5'h09
`define SCPU_OP_SET_BASE 5'h07
`define SCPU_OP_RET_IRQ 8'h2F
`define SCPU_OP_RET_SUB 8'h1F
`define SCPU_OP_PRESC_INT 8'h2E
`define SCPU_OP_RDY_LOW 8'h1C
`define SCPU_OP_SHL 8'h19
`define SCPU_OP_SHR 8'h18
`define SCPU_OP_POWER_DOWN 8'h5A
`define SCPU_OP_SUB_MEM 8'h17

// ************************************************************
// apb register byte offsets
// ************************************************************
`define SCPU_REG_CMD 8'h00
`define SCPU_REG_ACC 8'h04
`define SCPU_REG_XPTR 8'h08
`define SCPU_REG_STATUS 8'h0C
`define SCPU_REG_PC 8'h10
`define SCPU_REG_SPTR 8'h14
`define SCPU_REG_SER 8'h18
`define SCPU_REG_STK_TOP 8'h1C
`define SCPU_REG_RAM_IDX 8'h20
`define SCPU_REG_RAM_DATA 8'h24

// ************************************************************
// status register fields and the serializer count position
// ************************************************************
`define SCPU_ST_FLAG 0
`define SCPU_ST_SEXT 1
`define SCPU_ST_DOWN 2
`define SCPU_ST_RDY_N 3
`define SCPU_ST_PRESC 4
`define SCPU_ST_DEPTH_LSB 5
`define SCPU_SER_CNT_LSB 8

// ************************************************************
// reset values
// ************************************************************
`define SCPU_RST_PC 12'h000
`define SCPU_RST_IRQ_VEC 12'h010

`endif

// ==== shared/scpu_pkg.sv ====
// types for the speech cpu opcode group
`include "scpu_map.svh"
package scpu_pkg;
   timeunit 1ns;
   timeprecision 1ps;

   typedef enum logic [1:0] {
      SCPU_ST_IDLE = 2'b01,
      SCPU_ST_LOOK = 2'b10
   } scpu_state_t;

   typedef logic [`SCPU_STK_N-1:0][`SCPU_PC_W-1:0] scpu_stack_t;

   typedef struct packed {
      scpu_state_t st;
      logic [`SCPU_ACC_W-1:0] acc;
      logic [`SCPU_X_W-1:0] xptr;
      logic flag;
      logic [`SCPU_ACC_W-1:0] acc_save;
      logic [`SCPU_X_W-1:0] xptr_save;
      logic flag_save;
      logic sext;
      logic [`SCPU_PC_W-1:0] pc;
      logic [`SCPU_SPTR_W-1:0] sptr;
      logic [7:0] ser;
      logic [`SCPU_SER_CNT_W-1:0] ser_cnt;
      scpu_stack_t stk;
      logic [`SCPU_STK_CNT_W-1:0] depth;
      logic presc_int;
      logic rdy_n;
      logic down;
      logic [`SCPU_RAM_N-1:0][7:0] ram;
      logic [`SCPU_RAM_AW-1:0] ram_idx;
      logic [7:0] last_op;
      logic [`SCPU_SPTR_W-1:0] rom_addr;
      logic en_s1;
      logic en_s2;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } scpu_regs_t;

endpackage : scpu_pkg

// ==== test/scpu_host_model.sv ====
// far-side host that answers the ready handshake
module scpu_host_model (
   input wire logic pclk,
   input wire logic ready_n,
   input wire logic hold_low,
   input wire logic [3:0] dly,
   output logic host_enable_two_n
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // host
   // *****
   // dly sets how promptly the host answers
   initial begin
      host_enable_two_n = 1'b1;
      forever begin
         @(posedge pclk);
         if (hold_low) begin
            host_enable_two_n <= 1'b0;
         end else if (!ready_n) begin
            repeat (dly) @(posedge pclk);
            host_enable_two_n <= 1'b0;
            repeat (6) @(posedge pclk);
            host_enable_two_n <= 1'b1;
         end else begin
            host_enable_two_n <= 1'b1;
         end
      end
   end
endmodule : scpu_host_model

// ==== test/scpu_core_chk.sv ====
// port checker for the speech cpu opcode group
`include "scpu_map.svh"
module scpu_core_chk (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic [`SCPU_SPTR_W-1:0] rom_addr,
   input wire logic host_enable_two_n,
   input wire logic ready_n,
   input wire logic prescaler_internal_source,
   input wire logic power_down
);
   timeunit 1ns;
   timeprecision 1ps;
   // *****
   // helpers
   // *****
   logic wr_c, ex, lk;
   logic dn_q, la_v_q;
   logic [7:0] op;
   logic [`SCPU_SPTR_W-1:0] la_q;
   assign op = pwdata[7:0];
   assign wr_c = psel && penable && pwrite && pready && paddr == `SCPU_REG_CMD;
   assign ex = wr_c && !dn_q;
   assign lk = ex && op == `SCPU_OP_SER_LOOKUP;
   // a write to the speech pointer breaks the step chain
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dn_q <= 1'b0;
         la_v_q <= 1'b0;
         la_q <= '0;
      end else begin
         dn_q <= power_down;
         if (lk) begin
            la_v_q <= 1'b1;
            la_q <= rom_addr;
         end else if (psel && pwrite && paddr == `SCPU_REG_SPTR || ex) begin
            la_v_q <= 1'b0;
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   // *****
   // assertions
   // *****
   lookup_step_a: assert property (lk && la_v_q |-> rom_addr == la_q + 1'b1)
      else $error("lookup address did not step by one");
   addr_move_a: assert property ($changed(rom_addr) |-> pready)
      else $error("rom address moved without a command");
   presc_int_a: assert property (ex && op == `SCPU_OP_PRESC_INT
      |-> prescaler_internal_source) else $error("prescaler source not set");
   rdy_low_a: assert property (ex && op == `SCPU_OP_RDY_LOW &&
      $past(host_enable_two_n, 2) && $past(host_enable_two_n, 3) |-> !ready_n)
      else $error("ready pin not driven low");
   rdy_cause_a: assert property ($fell(ready_n) |->
      $past(host_enable_two_n, 3)) else $error("ready fell while host low");
   rdy_hi_a: assert property (!host_enable_two_n [*4] |-> ready_n)
      else $error("ready pin not released by host");
   down_enter_a: assert property (ex && op == `SCPU_OP_POWER_DOWN
      |-> power_down && !prescaler_internal_source && rom_addr == '0)
      else $error("power down did not clear outputs");
   down_hold_a: assert property (power_down &&
      !(psel && penable && paddr == `SCPU_REG_STATUS) |=> power_down)
      else $error("power down left without a wake write");
   cover property (lk);
   cover property ($rose(ready_n));
   cover property ($rose(power_down));
endmodule : scpu_core_chk

bind scpu_core scpu_core_chk chk_u (.pclk, .presetn, .psel, .penable, .pwrite,
   .paddr, .pwdata, .pready, .rom_addr, .host_enable_two_n, .ready_n,
   .prescaler_internal_source, .power_down);

// ==== test/testbench.sv ====
// self-checking bench for the speech cpu opcode group
`include "scpu_map.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CM = `SCPU_REG_CMD;
   localparam logic [7:0] AC = `SCPU_REG_ACC;
   localparam logic [7:0] XP = `SCPU_REG_XPTR;
   localparam logic [7:0] ST = `SCPU_REG_STATUS;
   localparam logic [7:0] PC = `SCPU_REG_PC;
   localparam logic [7:0] RI = `SCPU_REG_RAM_IDX;
   localparam logic [7:0] RD = `SCPU_REG_RAM_DATA;
   localparam logic [11:0] IRQV = 12'h010;
   logic pclk, presetn, psel, penable, pwrite, timer_irq, pready, pslverr;
   logic host_enable_two_n, ready_n, psrc, pdn, hold_low;
   logic [3:0] dly;
   logic [7:0] paddr, rom_data;
   logic [31:0] pwdata, prdata, rdat;
   logic [`SCPU_SPTR_W-1:0] rom_addr;
   logic [7:0] ops [10] = '{8'h57, 8'h48, 8'h38, 8'h1F, 8'h2E, 8'h1C,
      8'h19, 8'h18, 8'h85, 8'h59};
   int error_cnt, cmp_count, cyc;
   assign rom_data = rom_addr[7:0] ^ 8'hA5 ^ {2'b00, rom_addr[13:8]};
   scpu_core #(.IRQ_VECTOR(IRQV)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .timer_irq(timer_irq), .rom_addr(rom_addr), .rom_data(rom_data),
      .host_enable_two_n(host_enable_two_n), .ready_n(ready_n),
      .prescaler_internal_source(psrc), .power_down(pdn));
   scpu_host_model host_u (.pclk(pclk), .ready_n(ready_n),
      .hold_low(hold_low), .dly(dly), .host_enable_two_n(host_enable_two_n));
   // *****
   // tasks
   // *****
   task final_report;
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : final_report
   task chk(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         error_cnt++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // request held until pready is seen high at a rising edge
   task ap(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rdat = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : ap
   task wr(input logic [7:0] a, input logic [15:0] d);
      ap(1'b1, a, d);
   endtask : wr
   task cmd(input logic [7:0] op);
      ap(1'b1, CM, {8'h00, op});
   endtask : cmd
   task rc(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
      ap(1'b0, a, 16'h0000);
      chk(rdat[15:0] & m, e);
   endtask : rc
   task irq;
      @(posedge pclk);
      timer_irq <= 1'b1;
      @(posedge pclk);
      timer_irq <= 1'b0;
   endtask : irq
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 6000) begin
         error_cnt++;
         final_report();
      end
   end
   // *****
   // tests
   // *****
   initial begin
      {presetn, psel, penable, pwrite, timer_irq, hold_low} = 6'h00;
      paddr = 8'h00;
      pwdata = 32'h0000_0000;
      dly = 4'h3;
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      rc(ST, 16'h00FF, 16'h0008);
      ap(1'b0, 8'h30, 16'h0000);
      chk({15'h0000, pslverr}, 16'h0001);
      foreach (ops[i]) begin
         wr(ST, 16'h0000);
         cmd(ops[i]);
         rc(ST, 16'h0001, 16'h0001);
      end
      chk({15'h0000, psrc}, 16'h0001);
      wr(AC, 16'h02A5);
      cmd(`SCPU_OP_SHL);
      rc(AC, 16'h03FF, 16'h014A);
      wr(AC, 16'h02A5);
      wr(ST, 16'h0002);
      cmd(`SCPU_OP_SHR);
      rc(AC, 16'h03FF, 16'h0352);
      wr(XP, 16'h0005);
      wr(RI, 16'h0005);
      wr(RD, 16'h0000);
      for (int i = 0; i < 8; i++) begin
         cmd({`SCPU_OP_SET_BASE, 3'(i)});
         rc(RD, 16'h00FF, 16'((2 << i) - 1));
      end
      for (int i = 0; i < 8; i++) begin
         cmd({`SCPU_OP_CLR_BASE, 3'(i)});
         rc(RD, 16'h00FF, 16'(8'(8'hFF << (i + 1))));
      end
      wr(`SCPU_REG_SPTR, 16'h3FFF);
      cmd(`SCPU_OP_SER_LOOKUP);
      rc(`SCPU_REG_SER, 16'h0FFF, 16'h0865);
      rc(`SCPU_REG_SPTR, 16'h3FFF, 16'h0000);
      cmd(`SCPU_OP_SER_LOOKUP);
      rc(`SCPU_REG_SER, 16'h0FFF, 16'h08A5);
      rc(ST, 16'h00E0, 16'h0000);
      for (int i = 0; i < 6; i++) begin
         wr(PC, 16'h0100 + 16'(i));
         irq();
      end
      rc(ST, 16'h00E0, 16'h00A0);
      rc(PC, 16'h0FFF, {4'h0, IRQV});
      cmd(`SCPU_OP_POP);
      rc(`SCPU_REG_STK_TOP, 16'h0FFF, 16'h0104);
      for (int i = 4; i > 0; i--) begin
         cmd(`SCPU_OP_RET_SUB);
         rc(PC, 16'h0FFF, 16'h0100 + 16'(i));
      end
      rc(ST, 16'h00E0, 16'h0000);
      wr(AC, 16'h0155);
      wr(XP, 16'h0022);
      wr(ST, 16'h0001);
      wr(PC, 16'h0123);
      irq();
      wr(AC, 16'h0000);
      wr(XP, 16'h0000);
      wr(ST, 16'h0000);
      cmd(`SCPU_OP_RET_IRQ);
      rc(AC, 16'h03FF, 16'h0155);
      rc(XP, 16'h00FF, 16'h0022);
      rc(ST, 16'h0001, 16'h0001);
      rc(PC, 16'h0FFF, 16'h0123);
      wr(PC, 16'h007F);
      wr(ST, 16'h0001);
      cmd(8'h85);
      rc(PC, 16'h0FFF, 16'h0085);
      wr(PC, 16'h0200);
      wr(ST, 16'h0000);
      cmd(8'h85);
      rc(PC, 16'h0FFF, 16'h0201);
      wr(XP, 16'h0003);
      wr(RI, 16'h0003);
      wr(RD, 16'h0030);
      wr(AC, 16'h00F0);
      cmd(`SCPU_OP_SUB_MEM);
      rc(AC, 16'h03FF, 16'h00C0);
      rc(ST, 16'h0001, 16'h0001);
      wr(RD, 16'h00F1);
      cmd(`SCPU_OP_SUB_MEM);
      rc(AC, 16'h03FF, 16'h03CF);
      rc(ST, 16'h0001, 16'h0000);
      wr(ST, 16'h0003);
      wr(AC, 16'h0010);
      cmd(`SCPU_OP_SUB_MEM);
      rc(AC, 16'h03FF, 16'h001F);
      rc(ST, 16'h0001, 16'h0000);
      hold_low <= 1'b1;
      repeat (4) @(posedge pclk);
      cmd(`SCPU_OP_RDY_LOW);
      chk({15'h0000, ready_n}, 16'h0001);
      hold_low <= 1'b0;
      dly <= 4'h9;
      repeat (4) @(posedge pclk);
      cmd(`SCPU_OP_RDY_LOW);
      chk({15'h0000, ready_n}, 16'h0000);
      for (int w = 0; w < 30 && ready_n !== 1'b1; w++) @(posedge pclk);
      chk({15'h0000, ready_n}, 16'h0001);
      wr(RD, 16'h005A);
      wr(AC, 16'h0001);
      cmd(`SCPU_OP_POWER_DOWN);
      chk({14'h0000, pdn, psrc}, 16'h0002);
      cmd(`SCPU_OP_SHL);
      rc(AC, 16'h03FF, 16'h0001);
      rc(RD, 16'h00FF, 16'h005A);
      rc(CM, 16'h00FF, 16'h0019);
      wr(ST, 16'h0000);
      rc(ST, 16'h0004, 16'h0000);
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rc(ST, 16'h00FF, 16'h0008);
      rc(AC, 16'h03FF, 16'h0000);
      rc(RD, 16'h00FF, 16'h0000);
      final_report();
   end
endmodule : testbench
